//--- sim/core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Core side: instruction pulses and wake requests
// ----------------------------------------
module core_model (
    input wire logic clk,
    input wire logic stack_start,
    output logic wait_exec,
    output logic stop_exec,
    output logic int_wake
);
    int stacks = 0;
    initial begin
        wait_exec = 1'b0;
        stop_exec = 1'b0;
        int_wake = 1'b0;
    end
    // One-cycle instruction pulse
    task automatic exec_op(input logic is_stop);
        @(posedge clk);
        stop_exec <= is_stop;
        wait_exec <= ~is_stop;
        @(posedge clk);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
    endtask
    // Enabled interrupt held until stacking starts
    task automatic irq(output int lat);
        @(posedge clk);
        int_wake <= 1'b1;
        lat = 0;
        do begin
            @(posedge clk);
            #1;
            lat++;
        end while (stack_start !== 1'b1 && lat < 20);
        @(posedge clk);
        int_wake <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (stack_start === 1'b1) stacks++;
    end
endmodule

//--- sim/test_low_power_and_reset_status.sv
`timescale 1ns/100ps
module test_low_power_and_reset_status;
    logic CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, d;
    logic [1:0] HTRANS;
    logic WAIT_EXEC, STOP_EXEC, INT_WAKE, EXT_IRQ_N, BREAK_ACT, OPCODE_FETCH;
    logic RST_PIN_N, WDOG_OVF, ILLEGAL_ADDR, LVI_TRIP;
    logic [2:0] HSIZE;
    logic CPU_CLK_EN, PERIPH_CLK_EN, CLKGEN_EN, IMASK_CLR, STACK_START;
    logic SYS_CNT_CLR, WDOG_EN, ILLEGAL_OPCODE_FLAG_RST, FLAG_CLR_EN;
    logic [3:0] evt;
    logic [7:0] rs_exp;
    logic break_flag_clear_enable = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int lat, n;
    int bitpos [4] = '{6, 5, 3, 1};
    assign HREADY = HREADYOUT;
    assign RST_PIN_N = ~evt[0];
    assign WDOG_OVF = evt[1];
    assign ILLEGAL_ADDR = evt[2];
    assign LVI_TRIP = evt[3];
    low_power_and_reset_status u_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .WAIT_EXEC(WAIT_EXEC), .STOP_EXEC(STOP_EXEC),
        .INT_WAKE(INT_WAKE), .EXT_IRQ_N(EXT_IRQ_N), .BREAK_ACT(BREAK_ACT),
        .RST_PIN_N(RST_PIN_N), .WDOG_OVF(WDOG_OVF), .ILLEGAL_ADDR(ILLEGAL_ADDR),
        .OPCODE_FETCH(OPCODE_FETCH), .LVI_TRIP(LVI_TRIP), .CPU_CLK_EN(CPU_CLK_EN),
        .PERIPH_CLK_EN(PERIPH_CLK_EN), .CLKGEN_EN(CLKGEN_EN), .IMASK_CLR(IMASK_CLR),
        .STACK_START(STACK_START), .SYS_CNT_CLR(SYS_CNT_CLR), .WDOG_EN(WDOG_EN),
        .ILLEGAL_OPCODE_FLAG_RST(ILLEGAL_OPCODE_FLAG_RST), .FLAG_CLR_EN(FLAG_CLR_EN));
    core_model u_core (.clk(CLK), .stack_start(STACK_START), .wait_exec(WAIT_EXEC),
        .stop_exec(STOP_EXEC), .int_wake(INT_WAKE));
    // ----------------------------------------
    // Bus, compare and verdict tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chkb(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        HSIZE <= 3'h2;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chkb("hresp", HRESP, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        ahb(1'b1, a, wd);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m = 32'hffffffff);
        ahb(1'b0, a, 32'h0);
        check(nm, rd & m, e);
    endtask
    // Model of the reset source flags: a read clears unless protected in break
    task automatic rd_rs();
        rdchk("reset_source", lp_pkg::OFF_RESET_SOURCE, {24'h0, rs_exp});
        if (!(BREAK_ACT && !break_flag_clear_enable)) rs_exp = 8'h00;
    endtask
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 12000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HWDATA = 32'h0;
        EXT_IRQ_N = 1'b1;
        BREAK_ACT = 1'b0;
        OPCODE_FETCH = 1'b0;
        evt = 4'h0;
        HSIZE = 3'h0;
        void'($urandom(31));
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        rs_exp = 8'h80;
        rd_rs();
        rd_rs();
        wr(lp_pkg::OFF_RESET_SOURCE, 32'hff);
        rd_rs();
        rdchk("unmapped", 8'h3c, 32'h0);
        // Illegal address on a data fetch sets nothing
        @(posedge CLK) evt <= 4'h4;
        repeat (10) @(posedge CLK);
        evt <= 4'h0;
        rd_rs();
        for (int k = 0; k < 4; k++) begin
            @(posedge CLK) evt <= 4'h1 << k;
            OPCODE_FETCH <= 1'b1;
            repeat (10) @(posedge CLK);
            evt <= 4'h0;
            OPCODE_FETCH <= 1'b0;
            repeat (10) @(posedge CLK);
            rs_exp[bitpos[k]] = 1'b1;
            rd_rs();
        end
        u_core.exec_op(1'b1);
        #1;
        chkb("illegal_opcode_flag_rst", ILLEGAL_OPCODE_FLAG_RST, 1'b1);
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b1);
        rs_exp = 8'h10;
        rd_rs();
        // Wait entry, interrupt wake, break and reset exits
        u_core.exec_op(1'b0);
        #1;
        chkb("imask_clr", IMASK_CLR, 1'b1);
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b0);
        chkb("periph_clk_en", PERIPH_CLK_EN, 1'b1);
        chkb("wdog_en", WDOG_EN, 1'b1);
        rdchk("mode", lp_pkg::OFF_MODE_STATUS, 32'h1, 32'h3);
        u_core.irq(lat);
        check("wake_latency", lat, 32'h1);
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b1);
        u_core.exec_op(1'b0);
        n = u_core.stacks;
        @(posedge CLK) BREAK_ACT <= 1'b1;
        @(posedge CLK);
        @(posedge CLK) BREAK_ACT <= 1'b0;
        #1;
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b1);
        check("stacks", u_core.stacks, n);
        rdchk("break_status", lp_pkg::OFF_BREAK_STATUS, 32'h2);
        wr(lp_pkg::OFF_BREAK_STATUS, 32'h2);
        rdchk("break_status", lp_pkg::OFF_BREAK_STATUS, 32'h2);
        wr(lp_pkg::OFF_BREAK_STATUS, 32'h0);
        rdchk("break_status", lp_pkg::OFF_BREAK_STATUS, 32'h0);
        u_core.exec_op(1'b0);
        @(posedge CLK) evt <= 4'h2;
        @(posedge CLK) evt <= 4'h0;
        #1;
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b1);
        rdchk("break_status", lp_pkg::OFF_BREAK_STATUS, 32'h0);
        rs_exp = 8'h20;
        rd_rs();
        // Flag protection in break
        @(posedge CLK) BREAK_ACT <= 1'b1;
        evt <= 4'h2;
        @(posedge CLK) evt <= 4'h0;
        @(posedge CLK);
        #1;
        chkb("flag_clr_en", FLAG_CLR_EN, 1'b0);
        rs_exp = 8'h20;
        rd_rs();
        rd_rs();
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            wr(lp_pkg::OFF_BREAK_FLAG_CTRL, d);
            rdchk("bfc", lp_pkg::OFF_BREAK_FLAG_CTRL, {24'h0, d[7], 7'h0}, 32'h80);
        end
        wr(lp_pkg::OFF_BREAK_FLAG_CTRL, 32'h80);
        break_flag_clear_enable = 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        chkb("flag_clr_en", FLAG_CLR_EN, 1'b1);
        rd_rs();
        rd_rs();
        @(posedge CLK) BREAK_ACT <= 1'b0;
        // Stop entry, recovery and break exit
        wr(lp_pkg::OFF_CONFIG, 32'h2);
        u_core.exec_op(1'b1);
        #1;
        chkb("clkgen_en", CLKGEN_EN, 1'b0);
        chkb("periph_clk_en", PERIPH_CLK_EN, 1'b0);
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b0);
        chkb("sys_cnt_clr", SYS_CNT_CLR, 1'b1);
        chkb("imask_clr", IMASK_CLR, 1'b1);
        chkb("illegal_opcode_flag_rst", ILLEGAL_OPCODE_FLAG_RST, 1'b0);
        repeat (20) @(posedge CLK);
        #1;
        chkb("clkgen_en", CLKGEN_EN, 1'b0);
        @(posedge CLK) EXT_IRQ_N <= 1'b0;
        n = 0;
        while (CLKGEN_EN !== 1'b1 && n < 20) begin
            @(posedge CLK);
            #1;
            n++;
        end
        n = 0;
        while (STACK_START !== 1'b1 && n < 5000) begin
            @(posedge CLK);
            #1;
            n++;
        end
        check("recovery_len", n, lp_pkg::STOP_RECOVER_XCLK);
        chkb("cpu_clk_en", CPU_CLK_EN, 1'b1);
        @(posedge CLK) EXT_IRQ_N <= 1'b1;
        // Let the filtered interrupt pin go idle before the next stop
        repeat (6) @(posedge CLK);
        u_core.exec_op(1'b1);
        #1;
        chkb("clkgen_en", CLKGEN_EN, 1'b0);
        @(posedge CLK) BREAK_ACT <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        chkb("clkgen_en", CLKGEN_EN, 1'b1);
        @(posedge CLK) BREAK_ACT <= 1'b0;
        rdchk("mode", lp_pkg::OFF_MODE_STATUS, 32'h0, 32'h3);
        wr(lp_pkg::OFF_CONFIG, 32'h3);
        @(posedge CLK);
        #1;
        chkb("wdog_en", WDOG_EN, 1'b0);
        // Power-on reset in mid-run
        @(posedge CLK) RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        break_flag_clear_enable = 1'b0;
        repeat (4) @(posedge CLK);
        rs_exp = 8'h80;
        rd_rs();
        give_verdict();
    end
endmodule

//--- verilog/low_power_and_reset_status.sv
// Functional notes
// - Wait or stop instruction halts processor clock and clears interrupt mask
// - Interrupt mask clear pulses in the same step as low-power entry
// - Wait mode: processor clock off, peripheral clocks keep running
// - Interrupt wake from wait starts stacking one cycle later
// - Reset or break ends wait; break sets break-exit flag
// - Watchdog stays enabled through wait while disable bit is 0
// - Stop entry clears system counter, stops system clock and clock generator
// - External interrupt ends stop; stacking after 4096 crystal cycles
// - Reset or break also ends stop mode
// - Break-exit flag reads 1 when break ended wait, else 0
// - Writing 0 clears break-exit flag; any reset clears it too
// - Reset source register holds six cause flags; a read clears them
// - Power-on reset sets power-on flag, clears the other five
// - External reset line sets external flag; power-on or read clears
// - Watchdog overflow reset sets watchdog flag; power-on or read clears
// - Illegal opcode reset sets illegal opcode flag; power-on or read clears
// - Illegal address flag only on opcode fetch from illegal address
// - Low-voltage reset sets low-voltage flag; power-on or read clears
// - Break flag clear enable 1 allows flag clearing in break, 0 blocks
// - Stop without stop enable causes illegal opcode reset instead
// - Two-step flags stay protected in break; second step clears afterwards; here a write of 0 clears the break-exit flag even in break
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module low_power_and_reset_status (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic WAIT_EXEC,
    input wire logic STOP_EXEC,
    input wire logic INT_WAKE,
    input wire logic EXT_IRQ_N,
    input wire logic BREAK_ACT,
    input wire logic RST_PIN_N,
    input wire logic WDOG_OVF,
    input wire logic ILLEGAL_ADDR,
    input wire logic OPCODE_FETCH,
    input wire logic LVI_TRIP,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic CLKGEN_EN,
    output logic IMASK_CLR,
    output logic STACK_START,
    output logic SYS_CNT_CLR,
    output logic WDOG_EN,
    output logic ILLEGAL_OPCODE_FLAG_RST,
    output logic FLAG_CLR_EN
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] irq_sync;
    logic [2:0] pin_sync;
    logic irq_low;
    logic pin_low;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync <= 3'h7;
            pin_sync <= 3'h7;
            irq_low <= 1'b0;
            pin_low <= 1'b0;
        end else begin
            irq_sync <= {irq_sync[1:0], EXT_IRQ_N};
            pin_sync <= {pin_sync[1:0], RST_PIN_N};
            if (irq_sync[1] == irq_sync[2]) begin
                irq_low <= ~irq_sync[2];
            end
            if (pin_sync[1] == pin_sync[2]) begin
                pin_low <= ~pin_sync[2];
            end
        end
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    lp_pkg::lp_mode_t mode;
    lp_pkg::lp_mode_t next_mode;
    lp_pkg::rst_src_t rst_src;
    lp_pkg::rst_src_t src_set;
    lp_pkg::clk_en_t next_clk;
    logic brk_exit;
    logic [7:0] cfg;
    logic [7:0] bfc;
    logic stop_en;
    logic wd_dis;
    logic clr_en;
    logic illegal_address_flag_evt;
    logic rst_evt;
    logic [12:0] cnt;
    logic [12:0] next_cnt;
    logic next_imask;
    logic next_stack;
    logic next_cnt_clr;
    logic next_illegal_opcode_flag;

    assign stop_en = cfg[lp_pkg::CFG_STOP_EN_BIT];
    assign wd_dis = cfg[lp_pkg::CFG_WDOG_DIS_BIT];
    assign clr_en = ~BREAK_ACT | bfc[lp_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT];
    assign illegal_address_flag_evt = ILLEGAL_ADDR & OPCODE_FETCH;
    assign rst_evt = pin_low | WDOG_OVF | LVI_TRIP | illegal_address_flag_evt;

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic addr_ph;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic src_rd;
    logic brk_wr0;

    assign addr_ph = HSEL & HREADY & HTRANS[1];
    assign src_rd = addr_ph & ~HWRITE & reg_hit(HADDR[7:0], lp_pkg::OFF_RESET_SOURCE);
    assign brk_wr0 = wr_pend & reg_hit(wr_addr, lp_pkg::OFF_BREAK_STATUS)
                     & ~HWDATA[lp_pkg::BRK_EXIT_BIT];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            wr_pend <= addr_ph & HWRITE;
            if (addr_ph) begin
                wr_addr <= HADDR[7:0];
            end
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            HRDATA <= 32'h00000000;
        end else if (addr_ph && !HWRITE) begin
            HRDATA <= 32'h00000000;
            if (reg_hit(HADDR[7:0], lp_pkg::OFF_BREAK_STATUS)) begin
                HRDATA[lp_pkg::BRK_EXIT_BIT] <= brk_exit;
            end else if (reg_hit(HADDR[7:0], lp_pkg::OFF_RESET_SOURCE)) begin
                HRDATA[7:0] <= rst_src;
            end else if (reg_hit(HADDR[7:0], lp_pkg::OFF_BREAK_FLAG_CTRL)) begin
                HRDATA[7:0] <= bfc;
            end else if (reg_hit(HADDR[7:0], lp_pkg::OFF_CONFIG)) begin
                HRDATA[7:0] <= cfg;
            end else if (reg_hit(HADDR[7:0], lp_pkg::OFF_MODE_STATUS)) begin
                HRDATA[1:0] <= mode;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= lp_pkg::CONFIG_RESET;
            bfc <= lp_pkg::BREAK_FLAG_CTRL_RESET;
        end else if (wr_pend) begin
            if (reg_hit(wr_addr, lp_pkg::OFF_CONFIG)) begin
                cfg <= {6'h00, HWDATA[1:0]};
            end
            if (reg_hit(wr_addr, lp_pkg::OFF_BREAK_FLAG_CTRL)) begin
                bfc <= {HWDATA[lp_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT], 7'h00};
            end
        end
    end

    // ----------------------------------------
    // Break exit flag
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            brk_exit <= 1'b0;
        end else if (mode == lp_pkg::MODE_WAIT && BREAK_ACT) begin
            brk_exit <= 1'b1;
        end else if (brk_wr0 || rst_evt || next_illegal_opcode_flag) begin
            brk_exit <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reset source flags
    // ----------------------------------------
    always_comb begin
        src_set = '0;
        src_set.pin = pin_low;
        src_set.wdog = WDOG_OVF;
        src_set.illegal_opcode_flag = next_illegal_opcode_flag;
        src_set.illegal_address_flag = illegal_address_flag_evt;
        src_set.low_voltage_reset_flag = LVI_TRIP;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rst_src <= lp_pkg::RESET_SOURCE_POR;
        end else if (src_rd && clr_en) begin
            rst_src <= src_set;
        end else begin
            rst_src <= rst_src | src_set;
        end
    end

    // ----------------------------------------
    // Low-power sequencer
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        next_cnt = cnt;
        next_imask = 1'b0;
        next_stack = 1'b0;
        next_cnt_clr = 1'b0;
        next_illegal_opcode_flag = 1'b0;
        case (mode)
            lp_pkg::MODE_RUN: begin
                if (STOP_EXEC) begin
                    if (stop_en) begin
                        next_mode = lp_pkg::MODE_STOP;
                        next_imask = 1'b1;
                        next_cnt_clr = 1'b1;
                    end else begin
                        next_illegal_opcode_flag = 1'b1;
                    end
                end else if (WAIT_EXEC) begin
                    next_mode = lp_pkg::MODE_WAIT;
                    next_imask = 1'b1;
                end
            end
            lp_pkg::MODE_WAIT: begin
                if (rst_evt || BREAK_ACT) begin
                    next_mode = lp_pkg::MODE_RUN;
                end else if (INT_WAKE) begin
                    next_mode = lp_pkg::MODE_RUN;
                    next_stack = 1'b1;
                end
            end
            lp_pkg::MODE_STOP: begin
                if (rst_evt || BREAK_ACT) begin
                    next_mode = lp_pkg::MODE_RUN;
                end else if (irq_low) begin
                    next_mode = lp_pkg::MODE_RECOVER;
                    next_cnt = 13'(lp_pkg::STOP_RECOVER_CYC - 1);
                end
            end
            lp_pkg::MODE_RECOVER: begin
                if (rst_evt || BREAK_ACT) begin
                    next_mode = lp_pkg::MODE_RUN;
                end else if (cnt == 13'h0000) begin
                    next_mode = lp_pkg::MODE_RUN;
                    next_stack = 1'b1;
                end else begin
                    next_cnt = cnt - 13'h0001;
                end
            end
            default: begin
                next_mode = lp_pkg::MODE_RUN;
            end
        endcase
    end

    always_comb begin
        next_clk.cpu = (next_mode == lp_pkg::MODE_RUN);
        next_clk.periph = next_clk.cpu || (next_mode == lp_pkg::MODE_WAIT);
        next_clk.clkgen = (next_mode != lp_pkg::MODE_STOP);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode <= lp_pkg::MODE_RUN;
            cnt <= 13'h0000;
        end else begin
            mode <= next_mode;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CPU_CLK_EN <= 1'b1;
            PERIPH_CLK_EN <= 1'b1;
            CLKGEN_EN <= 1'b1;
            IMASK_CLR <= 1'b0;
            STACK_START <= 1'b0;
            SYS_CNT_CLR <= 1'b0;
            WDOG_EN <= 1'b1;
            ILLEGAL_OPCODE_FLAG_RST <= 1'b0;
            FLAG_CLR_EN <= 1'b1;
        end else begin
            CPU_CLK_EN <= next_clk.cpu;
            PERIPH_CLK_EN <= next_clk.periph;
            CLKGEN_EN <= next_clk.clkgen;
            IMASK_CLR <= next_imask;
            STACK_START <= next_stack;
            SYS_CNT_CLR <= next_cnt_clr;
            WDOG_EN <= ~wd_dis & (next_mode != lp_pkg::MODE_STOP);
            ILLEGAL_OPCODE_FLAG_RST <= next_illegal_opcode_flag;
            FLAG_CLR_EN <= clr_en;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [13:0] rec_seen;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rec_seen <= 14'h0000;
        end else if (mode == lp_pkg::MODE_RECOVER) begin
            rec_seen <= rec_seen + 14'h0001;
        end else begin
            rec_seen <= 14'h0000;
        end
    end

    a_entry_imask_clr: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_RUN && WAIT_EXEC && !STOP_EXEC)
        |=> IMASK_CLR && !CPU_CLK_EN && mode == lp_pkg::MODE_WAIT)
        else $error("wait entry did not gate cpu and clear mask");

    a_wait_clocks: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_WAIT) |-> (!CPU_CLK_EN && PERIPH_CLK_EN))
        else $error("wait mode clock gating wrong");

    a_wait_stack_start: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_WAIT && INT_WAKE && !BREAK_ACT && !rst_evt)
        |=> STACK_START ##1 !STACK_START)
        else $error("stacking not one cycle after wake");

    a_break_exit_flag: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_WAIT && BREAK_ACT)
        |=> brk_exit && mode == lp_pkg::MODE_RUN)
        else $error("break exit from wait not flagged");

    a_wdog_in_wait: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_WAIT && !wd_dis && $stable(wd_dis)) |-> WDOG_EN)
        else $error("watchdog off during wait");

    a_stop_clocks_off: assert property (
        @(posedge CLK) disable iff (!rst_n)
        $rose(mode == lp_pkg::MODE_STOP)
        |-> !CLKGEN_EN && !PERIPH_CLK_EN && $past(next_cnt_clr) && SYS_CNT_CLR)
        else $error("stop entry left clocks or counter running");

    a_stop_recover_len: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (STACK_START && $past(mode == lp_pkg::MODE_RECOVER)) |-> (rec_seen == 14'h1000))
        else $error("stop recovery delay not 4096 cycles");

    a_brk_flag_clear: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (brk_wr0 && !(mode == lp_pkg::MODE_WAIT && BREAK_ACT)) |=> !brk_exit)
        else $error("writing 0 did not clear break exit flag");

    a_src_read_clear: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (src_rd && clr_en && src_set == '0) |=> (rst_src == '0))
        else $error("reset source read did not clear flags");

    a_src_break_hold: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (src_rd && !clr_en) |=> $stable(rst_src) || $past(src_set) != '0)
        else $error("reset source cleared during protected break");

    a_stop_illegal: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (mode == lp_pkg::MODE_RUN && STOP_EXEC && !stop_en)
        |=> ILLEGAL_OPCODE_FLAG_RST && rst_src.illegal_opcode_flag && mode == lp_pkg::MODE_RUN)
        else $error("disabled stop did not raise illegal opcode reset");

endmodule

//--- verilog/lp_pkg.sv
package lp_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_BREAK_STATUS = 8'h00;
    localparam logic [7:0] OFF_RESET_SOURCE = 8'h04;
    localparam logic [7:0] OFF_BREAK_FLAG_CTRL = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_MODE_STATUS = 8'h10;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BRK_EXIT_BIT = 1;
    localparam int BREAK_FLAG_CLEAR_ENABLE_BIT = 7;
    localparam int CFG_WDOG_DIS_BIT = 0;
    localparam int CFG_STOP_EN_BIT = 1;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RESET_SOURCE_POR = 8'h80;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] BREAK_FLAG_CTRL_RESET = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    // Stop recovery time in crystal clock cycles; CLK is the crystal clock
    localparam int STOP_RECOVER_XCLK = 4096;
    localparam int CLK_PER_XCLK = 1;
    localparam int STOP_RECOVER_CYC = STOP_RECOVER_XCLK * CLK_PER_XCLK;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER} lp_mode_t;

    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic illegal_opcode_flag;
        logic illegal_address_flag;
        logic rsv2;
        logic low_voltage_reset_flag;
        logic rsv0;
    } rst_src_t;

    typedef struct packed {
        logic cpu;
        logic periph;
        logic clkgen;
    } clk_en_t;

endpackage
